// file: hdl/scrfc_pkg.sv
package scrfc_pkg;

    // ****************************************
    // widths and fetch geometry
    // ****************************************
    localparam int ADDR_W   = 32;            // byte address width
    localparam int WORD_W   = 32;            // one doubleword
    localparam int BURST_DW = 8;             // buffer depth in doublewords
    localparam int CNT_W    = 4;             // counts 0..8
    localparam int IDX_W    = 3;             // index 0..7

    localparam logic [CNT_W-1:0]  BURST_LEN   = 4'h8;          // dwords per fetch burst
    localparam logic [CNT_W-1:0]  INSTR_LEN   = 4'h2;          // dwords per instruction
    localparam logic [ADDR_W-1:0] DW_BYTES    = 32'h0000_0004; // bytes per dword
    localparam logic [ADDR_W-1:0] INSTR_BYTES = 32'h0000_0008; // bytes per instruction
    localparam logic [ADDR_W-1:0] RESET_ADDR  = 32'h0000_0000; // pointer value after reset

    // ****************************************
    // internal script ram window
    // ****************************************
    localparam logic [ADDR_W-1:0] RAM_BASE = 32'h0008_0000;    // first byte of on-chip ram
    localparam logic [ADDR_W-1:0] RAM_SIZE = 32'h0000_2000;    // window size in bytes

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS    = 10;                               // 100 MHz core clock
    localparam int FETCH_DECODE_NS  = 500;                              // fetch plus decode budget
    localparam int FETCH_DECODE_CYC = FETCH_DECODE_NS / CLK_PERIOD_NS;  // longest time, rounded down

    // ****************************************
    // states, causes and carriers
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_FETCH  = 2'b01,
        ST_DECODE = 2'b10,
        ST_EXEC   = 2'b11
    } scrfc_state_type;

    typedef enum logic [1:0] {
        IRQ_NONE   = 2'b00,
        IRQ_SCRIPT = 2'b01,
        IRQ_HWERR  = 2'b10
    } scrfc_cause_type;

    typedef struct packed {
        logic              req;   // burst read request, held until accepted
        logic [ADDR_W-1:0] addr;  // first byte address
        logic [CNT_W-1:0]  len;   // dwords in the burst
    } scrfc_dma_req_type;

    typedef struct packed {
        logic              valid; // one-cycle pulse
        logic [ADDR_W-1:0] addr;  // address of the instruction
        logic [WORD_W-1:0] word0; // first dword
        logic [WORD_W-1:0] word1; // second dword
    } scrfc_instr_type;

endpackage

// file: hdl/scrfc_word_buf.sv
`timescale 1ns/1ps

module scrfc_word_buf
    import scrfc_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // fill side
    input  wire logic              clear_i,
    input  wire logic              wr_en_i,
    input  wire logic [WORD_W-1:0] wr_data_i,
    // read side
    input  wire logic [IDX_W-1:0]  rd_idx_i,
    output logic      [CNT_W-1:0]  count_o,
    output logic      [WORD_W-1:0] rd_word0_o,
    output logic      [WORD_W-1:0] rd_word1_o
);

    // ****************************************
    // storage
    // ****************************************
    logic [WORD_W-1:0] mem_q [BURST_DW];  // fetched dwords
    logic [CNT_W-1:0]  count_q;           // dwords held

    // fill count, saturates at a full burst
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || clear_i)
            count_q <= '0;
        else if (wr_en_i && (count_q < BURST_LEN))
            count_q <= count_q + 4'h1;
    end

    // one entry per generated slot, written in arrival order
    for (genvar g = 0; g < BURST_DW; g++)
    begin : g_entry
        always_ff @(posedge core_clk_i)
        begin
            if (rst_i)
                mem_q[g] <= '0;
            else if (wr_en_i && (count_q == CNT_W'(g)))
                mem_q[g] <= wr_data_i;
        end
    end

    // instruction pair read, second index wraps harmlessly
    assign count_o    = count_q;
    assign rd_word0_o = mem_q[rd_idx_i];
    assign rd_word1_o = mem_q[IDX_W'(rd_idx_i + 1'b1)];

endmodule

// file: hdl/scrfc_fetch_ctrl.sv
`timescale 1ns/1ps

// Behaviour
// - start write triggers bus-master fetch of first
// - device fetches all following instructions itself
// - fetch bursts of at most eight dwords
// - run until script interrupt or hardware error
// - interrupt host only on completion or service
// - fetch plus decode within 500 ns; only internal ram fetches are bounded, bus fetches wait on the memory ack
// - dual-edge mode captures data on both strobe edges
// - internal ram fetches make no bus cycles
module scrfc_fetch_ctrl
    import scrfc_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // host register writes
    input  wire logic              start_wr_i,
    input  wire logic [ADDR_W-1:0] start_addr_i,
    input  wire logic              dsa_wr_i,
    input  wire logic [ADDR_W-1:0] dsa_addr_i,
    // host status
    output logic                   irq_o,
    output scrfc_cause_type        irq_cause_o,
    output logic                   busy_o,
    // system memory burst master
    output scrfc_dma_req_type      dma_o,
    input  wire logic              dma_ack_i,
    input  wire logic              dma_rvalid_i,
    input  wire logic [WORD_W-1:0] dma_rdata_i,
    input  wire logic              dma_err_i,
    // internal script ram
    input  wire logic              ram_present_i,
    output logic                   ram_rd_o,
    output logic      [ADDR_W-1:0] ram_addr_o,
    input  wire logic              ram_rvalid_i,
    input  wire logic [WORD_W-1:0] ram_rdata_i,
    // execution engine
    output scrfc_instr_type        instr_o,
    output logic      [ADDR_W-1:0] dsa_o,
    input  wire logic              exec_done_i,
    input  wire logic              exec_int_i,
    input  wire logic              exec_jump_i,
    input  wire logic [ADDR_W-1:0] exec_jump_addr_i,
    input  wire logic              ext_err_i,
    // bus transfer strobe capture
    input  wire logic              dual_edge_transfer_i,
    input  wire logic              xfer_req_i,
    input  wire logic [WORD_W-1:0] xfer_data_i,
    output logic                   xfer_valid_o,
    output logic      [WORD_W-1:0] xfer_data_o
);

    // ****************************************
    // declarations
    // ****************************************
    localparam int FD_MAX = FETCH_DECODE_CYC;  // cycle budget for assertions

    scrfc_state_type   state_q;       // sequencer state
    logic [ADDR_W-1:0] pc_q;          // next instruction address
    logic [ADDR_W-1:0] fa_q;          // next ram read address
    logic [CNT_W-1:0]  issued_q;      // ram reads issued this burst
    logic [CNT_W-1:0]  rd_q;          // buffer read position
    logic              in_ram_q;      // burst served by internal ram
    logic              busy_q;        // run in progress
    logic              irq_q;         // interrupt pending
    scrfc_cause_type   cause_q;       // why the run ended
    logic [ADDR_W-1:0] dsa_q;         // table base pointer
    scrfc_dma_req_type dma_q;         // burst request
    logic              ram_rd_q;      // ram read strobe
    logic [ADDR_W-1:0] ram_addr_q;    // ram read address
    scrfc_instr_type   instr_q;       // decoded instruction
    logic              strb_q;        // last strobe level
    logic              xvalid_q;      // captured data valid
    logic [WORD_W-1:0] xdata_q;       // captured data

    logic              launch;        // start a new burst
    logic [ADDR_W-1:0] launch_addr;   // where the burst starts
    logic              launch_ram;    // burst goes to internal ram
    logic              err_ev;        // hardware error during a run
    logic              have_instr;    // a whole instruction is buffered
    logic              buf_wr;        // word arrives for the buffer
    logic [WORD_W-1:0] buf_wdata;     // arriving word
    logic [CNT_W-1:0]  buf_count;     // words in the buffer
    logic [WORD_W-1:0] buf_w0;        // first word at read position
    logic [WORD_W-1:0] buf_w1;        // second word at read position
    logic              strb_edge;     // strobe edge that carries data

    // address falls inside the internal ram window
    function automatic logic in_ram_window(input logic [ADDR_W-1:0] addr);
        in_ram_window = (addr >= RAM_BASE) && ((addr - RAM_BASE) < RAM_SIZE);
    endfunction

    // ****************************************
    // burst launch decisions
    // ****************************************

    // new burst from start write, exhausted buffer or branch
    always_comb
    begin
        launch      = 1'b0;
        launch_addr = pc_q;
        unique case (state_q)
            ST_IDLE:
            begin
                launch      = start_wr_i;
                launch_addr = start_addr_i;
            end
            ST_DECODE:
                launch = !have_instr;
            ST_EXEC:
            begin
                // branch drops the prefetched words
                launch      = exec_done_i && !exec_int_i && exec_jump_i;
                launch_addr = exec_jump_addr_i;
            end
            ST_FETCH:
                launch = 1'b0;
        endcase
        if (err_ev)
            launch = 1'b0;
        launch_ram = ram_present_i && in_ram_window(launch_addr);
    end

    assign err_ev     = (state_q != ST_IDLE) && (dma_err_i || ext_err_i);
    assign have_instr = (rd_q + INSTR_LEN) <= buf_count;
    assign buf_wr     = (state_q == ST_FETCH) && (in_ram_q ? ram_rvalid_i : dma_rvalid_i);
    assign buf_wdata  = in_ram_q ? ram_rdata_i : dma_rdata_i;

    // ****************************************
    // sequencer
    // ****************************************

    // state walk and instruction pointer
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            state_q  <= ST_IDLE;
            pc_q     <= RESET_ADDR;
            rd_q     <= '0;
            in_ram_q <= 1'b0;
            busy_q   <= 1'b0;
        end
        else if (err_ev)
        begin
            // abort any fetch or execution
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
        end
        else if (launch)
        begin
            state_q  <= ST_FETCH;
            pc_q     <= launch_addr;
            rd_q     <= '0;
            in_ram_q <= launch_ram;
            busy_q   <= 1'b1;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                    state_q <= ST_IDLE;
                ST_FETCH:
                    if (buf_count == BURST_LEN)
                        state_q <= ST_DECODE;
                ST_DECODE:
                begin
                    // whole instruction present, hand it over
                    state_q <= ST_EXEC;
                    pc_q    <= pc_q + INSTR_BYTES;
                    rd_q    <= rd_q + INSTR_LEN;
                end
                ST_EXEC:
                    if (exec_done_i && exec_int_i)
                    begin
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                    end
                    else if (exec_done_i)
                        state_q <= ST_DECODE;
            endcase
        end
    end

    // instruction hand-over, one-cycle valid
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            instr_q <= '0;
        else
        begin
            instr_q.valid <= (state_q == ST_DECODE) && have_instr && !err_ev;
            if ((state_q == ST_DECODE) && have_instr)
            begin
                instr_q.addr  <= pc_q;
                instr_q.word0 <= buf_w0;
                instr_q.word1 <= buf_w1;
            end
        end
    end

    // ****************************************
    // fetch paths
    // ****************************************

    // system memory burst request, held until accepted
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            dma_q <= '0;
        else if (err_ev)
            dma_q.req <= 1'b0;
        else if (launch && !launch_ram)
        begin
            dma_q.req  <= 1'b1;
            dma_q.addr <= launch_addr;
            dma_q.len  <= BURST_LEN;
        end
        else if (dma_ack_i)
            dma_q.req <= 1'b0;
    end

    // internal ram reads, one dword a cycle, no bus traffic
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            fa_q       <= RESET_ADDR;
            issued_q   <= '0;
            ram_rd_q   <= 1'b0;
            ram_addr_q <= RESET_ADDR;
        end
        else if (launch)
        begin
            fa_q     <= launch_addr;
            issued_q <= '0;
            ram_rd_q <= 1'b0;
        end
        else if ((state_q == ST_FETCH) && in_ram_q && (issued_q < BURST_LEN) && !err_ev)
        begin
            ram_rd_q   <= 1'b1;
            ram_addr_q <= fa_q;
            fa_q       <= fa_q + DW_BYTES;
            issued_q   <= issued_q + 4'h1;
        end
        else
            ram_rd_q <= 1'b0;
    end

    // burst words land here for decoding
    scrfc_word_buf u_buf (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .clear_i    (launch),
        .wr_en_i    (buf_wr),
        .wr_data_i  (buf_wdata),
        .rd_idx_i   (rd_q[IDX_W-1:0]),
        .count_o    (buf_count),
        .rd_word0_o (buf_w0),
        .rd_word1_o (buf_w1)
    );

    // ****************************************
    // host side registers
    // ****************************************

    // interrupt only at end of run, cleared by restart
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            irq_q   <= 1'b0;
            cause_q <= IRQ_NONE;
        end
        else if (err_ev)
        begin
            irq_q   <= 1'b1;
            cause_q <= IRQ_HWERR;
        end
        else if ((state_q == ST_EXEC) && exec_done_i && exec_int_i)
        begin
            irq_q   <= 1'b1;
            cause_q <= IRQ_SCRIPT;
        end
        else if ((state_q == ST_IDLE) && start_wr_i)
        begin
            irq_q   <= 1'b0;
            cause_q <= IRQ_NONE;
        end
    end

    // table base pointer, written whenever the host likes
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            dsa_q <= RESET_ADDR;
        else if (dsa_wr_i)
            dsa_q <= dsa_addr_i;
    end

    // ****************************************
    // strobe capture
    // ****************************************

    // rising edge always, falling edge too in dual-edge mode
    assign strb_edge = (xfer_req_i && !strb_q) || (dual_edge_transfer_i && !xfer_req_i && strb_q);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            strb_q   <= 1'b0;
            xvalid_q <= 1'b0;
            xdata_q  <= '0;
        end
        else
        begin
            strb_q   <= xfer_req_i;
            xvalid_q <= strb_edge;
            if (strb_edge)
                xdata_q <= xfer_data_i;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign irq_o        = irq_q;
    assign irq_cause_o  = cause_q;
    assign busy_o       = busy_q;
    assign dma_o        = dma_q;
    assign ram_rd_o     = ram_rd_q;
    assign ram_addr_o   = ram_addr_q;
    assign instr_o      = instr_q;
    assign dsa_o        = dsa_q;
    assign xfer_valid_o = xvalid_q;
    assign xfer_data_o  = xdata_q;

    // ****************************************
    // assertions
    // ****************************************
    start_launch_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state_q == ST_IDLE) && start_wr_i && !(ram_present_i && in_ram_window(start_addr_i)) && !ext_err_i
        |=> dma_o.req && (dma_o.addr == $past(start_addr_i)))
        else $error("start write did not launch a burst");

    buffer_refill_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state_q == ST_DECODE) && !have_instr && !err_ev |=> (state_q == ST_FETCH) && (pc_q == $past(pc_q)))
        else $error("empty buffer did not trigger a refill");

    burst_len_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dma_o.req |-> (dma_o.len == BURST_LEN) && (buf_count <= BURST_LEN))
        else $error("burst length out of range");

    script_stop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state_q == ST_EXEC) && exec_done_i && exec_int_i && !err_ev
        |=> (state_q == ST_IDLE) && irq_o && (irq_cause_o == IRQ_SCRIPT))
        else $error("script interrupt did not end the run");

    hw_error_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        err_ev |=> (state_q == ST_IDLE) && irq_o && (irq_cause_o == IRQ_HWERR) && !dma_o.req)
        else $error("hardware error did not end the run");

    irq_cause_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(irq_o) |-> $past(err_ev) || ($past(state_q == ST_EXEC) && $past(exec_done_i && exec_int_i)))
        else $error("interrupt raised without a cause");

    fetch_time_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state_q == ST_FETCH) && $changed(state_q) && in_ram_q
        |-> ##[1:FD_MAX] (instr_o.valid || (state_q == ST_IDLE)))
        else $error("fetch and decode took too long");

    dual_edge_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $fell(xfer_req_i) |=> (xfer_valid_o == $past(dual_edge_transfer_i)) &&
        (!xfer_valid_o || (xfer_data_o == $past(xfer_data_i))))
        else $error("falling strobe edge handled wrongly");

    ram_quiet_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        in_ram_q && (state_q == ST_FETCH) |-> !dma_o.req)
        else $error("bus request during ram fetch");

    idle_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state_q == ST_IDLE) && !start_wr_i |=> (state_q == ST_IDLE) && !dma_o.req && !ram_rd_o && !instr_o.valid)
        else $error("activity while idle");

endmodule

// file: sim/scrfc_mem_model.sv
`timescale 1ns/1ps

module scrfc_mem_model
    import scrfc_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // burst master side
    input  wire scrfc_dma_req_type dma_i,
    input  wire logic [3:0]        ack_dly_i,
    output logic                   dma_ack_o,
    output logic                   dma_rvalid_o,
    output logic      [WORD_W-1:0] dma_rdata_o,
    // script ram side
    input  wire logic              ram_rd_i,
    input  wire logic [ADDR_W-1:0] ram_addr_i,
    output logic                   ram_rvalid_o,
    output logic      [WORD_W-1:0] ram_rdata_o
);
    logic [3:0]        wait_q;  // cycles stalled before accepting
    logic [CNT_W-1:0]  beats_q; // beats still owed
    logic [ADDR_W-1:0] addr_q;  // address of next beat

    // memory contents derived from the byte address
    function automatic logic [WORD_W-1:0] mem_word(input logic [ADDR_W-1:0] a);
        return {a[15:0] ^ 16'h5a5a, a[31:16]};
    endfunction

    // ****************
    // burst acceptance and beats
    // ****************
    always_ff @(posedge core_clk_i)
    begin
        dma_ack_o    <= 1'b0;
        dma_rvalid_o <= 1'b0;
        dma_rdata_o  <= ~dma_rdata_o; // idle data keeps moving
        if (rst_i)
        begin
            wait_q      <= 4'h0;
            beats_q     <= 4'h0;
            dma_rdata_o <= 32'h0000_0000;
        end
        else if (beats_q != 4'h0)
        begin
            dma_rvalid_o <= 1'b1;
            dma_rdata_o  <= mem_word(addr_q);
            addr_q       <= addr_q + DW_BYTES;
            beats_q      <= beats_q - 4'h1;
        end
        else if (dma_i.req && !dma_ack_o)
        begin
            wait_q <= wait_q + 4'h1;
            if (wait_q >= ack_dly_i)
            begin
                dma_ack_o <= 1'b1;
                addr_q    <= dma_i.addr;
                beats_q   <= dma_i.len;
                wait_q    <= 4'h0;
            end
        end
    end

    // ram answers one cycle after each read
    always_ff @(posedge core_clk_i)
    begin
        ram_rvalid_o <= ram_rd_i & ~rst_i;
        ram_rdata_o  <= rst_i ? '0 : (ram_rd_i ? mem_word(ram_addr_i) : ~ram_rdata_o);
    end
endmodule

// file: sim/script_fetch_start_control_test.sv
`timescale 1ns/1ps

module script_fetch_start_control_test
    import scrfc_pkg::*;
;
    // ****************
    // connections and bookkeeping
    // ****************
    logic              core_clk_i, rst_i, start_wr_i, dsa_wr_i, irq_o, busy_o, ram_rd_o;
    logic [ADDR_W-1:0] start_addr_i, dsa_addr_i, dsa_o, ram_addr_o, exec_jump_addr_i, base, req_a;
    logic              dma_ack_i, dma_rvalid_i, dma_err_i, ram_present_i, ram_rvalid_i;
    logic [WORD_W-1:0] dma_rdata_i, ram_rdata_i, xfer_data_i, xfer_data_o;
    logic              exec_done_i, exec_int_i, exec_jump_i, ext_err_i;
    logic              dual_edge_transfer_i, xfer_req_i, xfer_valid_o;
    logic [3:0]        ack_dly;     // memory stall before accept
    logic [CNT_W-1:0]  req_l;       // length of last accepted burst
    scrfc_cause_type   irq_cause_o;
    scrfc_dma_req_type dma_o;
    scrfc_instr_type   instr_o;
    int                fail_count, samples_checked, cycles, req_n, ins_n, xv_n, t0, t1, n;
    integer            seed = 32'h3a55;

    scrfc_fetch_ctrl scrfc_fetch_ctrl_inst (.core_clk_i, .rst_i, .start_wr_i, .start_addr_i, .dsa_wr_i,
        .dsa_addr_i, .irq_o, .irq_cause_o, .busy_o, .dma_o, .dma_ack_i, .dma_rvalid_i, .dma_rdata_i,
        .dma_err_i, .ram_present_i, .ram_rd_o, .ram_addr_o, .ram_rvalid_i, .ram_rdata_i, .instr_o, .dsa_o,
        .exec_done_i, .exec_int_i, .exec_jump_i, .exec_jump_addr_i, .ext_err_i, .dual_edge_transfer_i,
        .xfer_req_i, .xfer_data_i, .xfer_valid_o, .xfer_data_o);

    scrfc_mem_model scrfc_mem_model_inst (.core_clk_i, .rst_i, .dma_i(dma_o), .ack_dly_i(ack_dly),
        .dma_ack_o(dma_ack_i), .dma_rvalid_o(dma_rvalid_i), .dma_rdata_o(dma_rdata_i), .ram_rd_i(ram_rd_o),
        .ram_addr_i(ram_addr_o), .ram_rvalid_o(ram_rvalid_i), .ram_rdata_o(ram_rdata_i));

    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // burst, instruction and capture monitors, hang limit
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (dma_o.req && dma_ack_i)
        begin
            req_n++;
            req_a = dma_o.addr;
            req_l = dma_o.len;
        end
        if (instr_o.valid) ins_n++;
        if (xfer_valid_o) xv_n++;
        if (cycles == 5000)
        begin
            fail_count++;
            results();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] wexp(input logic [31:0] a);
        return {a[15:0] ^ 16'h5a5a, a[31:16]};
    endfunction

    task automatic launch(input logic [31:0] a);
        @(posedge core_clk_i);
        start_wr_i   <= 1'b1;
        start_addr_i <= a;
        ack_dly      <= 4'($random(seed) & 7);
        @(posedge core_clk_i);
        start_wr_i   <= 1'b0;
    endtask

    task automatic get_instr(input logic [31:0] a, output int w);
        w = 0;
        while (instr_o.valid !== 1'b1 && w < 300)
        begin
            @(negedge core_clk_i);
            w++;
        end
        chk("instr addr", a, instr_o.addr);
        chk("instr word0", wexp(a), instr_o.word0);
        chk("instr word1", wexp(a + DW_BYTES), instr_o.word1);
    endtask

    task automatic step(input logic i_f, input logic j_f, input logic [31:0] ja);
        @(posedge core_clk_i);
        exec_done_i      <= 1'b1;
        exec_int_i       <= i_f;
        exec_jump_i      <= j_f;
        exec_jump_addr_i <= ja;
        @(posedge core_clk_i);
        {exec_done_i, exec_int_i, exec_jump_i} <= 3'h0;
    endtask

    task automatic ended(input logic [31:0] cause);
        repeat (3) @(negedge core_clk_i);
        chk("irq", 32'h1, 32'(irq_o));
        chk("cause", cause, 32'(irq_cause_o));
        chk("busy", 32'h0, 32'(busy_o));
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        {start_wr_i, start_addr_i, dsa_wr_i, dsa_addr_i, dma_err_i, ram_present_i, ext_err_i} = '0;
        {exec_done_i, exec_int_i, exec_jump_i, exec_jump_addr_i, ack_dly} = '0;
        {dual_edge_transfer_i, xfer_req_i, xfer_data_i} = '0;
        rst_i = 1'b1;
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        // memory run: pointer, launch, refill, script interrupt
        base = $random(seed) & 32'h0007_ffe0;
        @(posedge core_clk_i);
        dsa_wr_i   <= 1'b1;
        dsa_addr_i <= ~base;
        @(posedge core_clk_i);
        dsa_wr_i   <= 1'b0;
        @(negedge core_clk_i);
        chk("table pointer", ~base, dsa_o);
        launch(base);
        for (int i = 0; i < 5; i++)
        begin
            get_instr(base + 32'(i) * INSTR_BYTES, n);
            chk("burst addr", base + ((i == 4) ? BURST_LEN * DW_BYTES : 0), req_a);
            chk("burst len", 32'(BURST_LEN), 32'(req_l));
            step(i == 4, 1'b0, 32'h0000_0000);
        end
        ended(32'(IRQ_SCRIPT));
        t0 = req_n;
        t1 = ins_n;
        @(posedge core_clk_i);
        ext_err_i <= 1'b1;
        @(posedge core_clk_i);
        ext_err_i <= 1'b0;
        repeat (30) @(negedge core_clk_i);
        chk("idle bursts", t0, req_n);
        chk("idle instrs", t1, ins_n);
        chk("idle cause", 32'(IRQ_SCRIPT), 32'(irq_cause_o));
        $display("test memory_run done");
        // jump, start while busy, external error
        base = 32'h0004_0000 | ($random(seed) & 32'h0000_ffe0);
        launch(base);
        get_instr(base, n);
        chk("irq cleared", 32'h0, 32'(irq_o));
        chk("busy run", 32'h1, 32'(busy_o));
        launch(32'h0001_0000);
        step(1'b0, 1'b1, base + 32'h0000_0100);
        get_instr(base + 32'h0000_0100, n);
        chk("jump burst", base + 32'h0000_0100, req_a);
        @(posedge core_clk_i);
        ext_err_i <= 1'b1;
        @(posedge core_clk_i);
        ext_err_i <= 1'b0;
        ended(32'(IRQ_HWERR));
        $display("test jump_error done");
        // bus error while the fetch waits
        launch(base);
        ack_dly   <= 4'hf;
        dma_err_i <= 1'b1;
        @(posedge core_clk_i);
        dma_err_i <= 1'b0;
        ended(32'(IRQ_HWERR));
        chk("req dropped", 32'h0, 32'(dma_o.req));
        repeat (20) @(posedge core_clk_i);
        $display("test bus_error done");
        // internal ram run
        ram_present_i <= 1'b1;
        base = RAM_BASE + ($random(seed) & 32'h0000_1fc0);
        t0 = req_n;
        launch(base);
        get_instr(base, n);
        chk("fetch time", 32'h1, 32'(n <= FETCH_DECODE_CYC));
        step(1'b0, 1'b0, 32'h0000_0000);
        get_instr(base + INSTR_BYTES, n);
        chk("ram bursts", t0, req_n);
        step(1'b1, 1'b0, 32'h0000_0000);
        ended(32'(IRQ_SCRIPT));
        $display("test ram_run done");
        // strobe capture in both modes
        for (int m = 0; m < 2; m++)
        begin
            @(posedge core_clk_i);
            dual_edge_transfer_i <= m[0];
            t0 = xv_n;
            for (int k = 0; k < 4; k++)
            begin
                repeat (3) @(posedge core_clk_i);
                xfer_req_i  <= ~xfer_req_i;
                xfer_data_i <= $random(seed);
            end
            repeat (4) @(posedge core_clk_i);
            chk("strobe edges", 32'(2 + 2 * m), 32'(xv_n - t0));
        end
        chk("last capture", xfer_data_i, xfer_data_o);
        $display("test strobe done");
        results();
    end
endmodule
